// File: hw/xsde_exec.sv
// Summary of operation
// RQ1: literal xor into accumulator, always
// RQ2: register xor with 7-bit indexed register
// RQ3: target bit 0 accumulator, 1 register
// RQ4: xor sets only zero flag from result
// RQ5: one instruction in four phases Q1-Q4
// RQ6: direction load copies accumulator, regs addressable
// RQ7: nibble exchange swaps halves, flags untouched
module xsde_exec
  import xsde_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_insn_valid,
  input wire logic [13:0] i_insn,
  output logic [7:0] o_acc,
  output logic o_zero,
  output logic o_zero_we,
  output logic o_busy,
  output logic o_done,
  output logic o_reg_we,
  output logic [6:0] o_reg_idx,
  output logic [7:0] o_reg_data,
  output logic [7:0] o_dir_a,
  output logic [7:0] o_dir_b,
  output logic [7:0] o_dir_c
);
  typedef enum logic [2:0]
  {
    xsde_idle,
    xsde_q1,
    xsde_q2,
    xsde_q3,
    xsde_q4
  } xsde_state_type;

  xsde_dec_type dec_w;
  xsde_dec_type dec_q, dec_d;
  xsde_state_type state_q, state_d;
  logic [13:0] insn_q, insn_d;
  logic [7:0] opnd_q, opnd_d;
  logic [7:0] res_q, res_d;
  logic [7:0] acc_q, acc_d;
  logic zero_q, zero_d;
  logic zero_we_q, zero_we_d;
  logic done_q, done_d;
  xsde_wr_type wr_q, wr_d;
  logic [7:0] dir_q [3];
  logic [7:0] dir_d [3];
  logic [7:0] ram_q [128];
  logic [7:0] rd_w;

  xsde_decode u_decode
  (
    .i_insn(insn_q),
    .o_dec(dec_w)
  );

  // data registers; direction registers live at their own indices
  always_comb
  begin
    rd_w = ram_q[dec_q.idx];
    if (dec_q.idx >= xsde_dir_idx_lo && dec_q.idx <= xsde_dir_idx_hi)
    begin
      rd_w = dir_q[2'(dec_q.idx - xsde_dir_idx_lo)]; // RQ6
    end
  end

  always_comb
  begin
    state_d = state_q;
    insn_d = insn_q;
    dec_d = dec_q;
    opnd_d = opnd_q;
    res_d = res_q;
    acc_d = acc_q;
    zero_d = zero_q;
    zero_we_d = 1'b0;
    done_d = 1'b0;
    wr_d = '0;
    for (int i = 0; i < 3; i++)
    begin
      dir_d[i] = dir_q[i];
    end
    case (state_q)
      xsde_idle:
      begin
        if (i_insn_valid)
        begin
          insn_d = i_insn;
          state_d = xsde_q1;
        end
      end
      xsde_q1:
      begin
        dec_d = dec_w; // RQ5
        state_d = xsde_q2;
      end
      xsde_q2:
      begin
        opnd_d = (dec_q.op == xsde_xor_literal) ? dec_q.lit : rd_w; // RQ5
        state_d = xsde_q3;
      end
      xsde_q3:
      begin
        case (dec_q.op)
          xsde_xor_literal: res_d = acc_q ^ opnd_q; // RQ1
          xsde_xor_register: res_d = acc_q ^ opnd_q; // RQ2
          xsde_nibble_exchange: res_d = {opnd_q[3:0], opnd_q[7:4]}; // RQ7
          xsde_load_direction_reg: res_d = acc_q; // RQ6
          default: res_d = opnd_q;
        endcase
        state_d = xsde_q4;
      end
      xsde_q4:
      begin
        done_d = 1'b1; // RQ5
        state_d = xsde_idle;
        case (dec_q.op)
          xsde_xor_literal:
          begin
            acc_d = res_q; // RQ1
          end
          xsde_xor_register, xsde_nibble_exchange:
          begin
            if (dec_q.to_reg)
            begin
              wr_d = '{en: 1'b1, idx: dec_q.idx, data: res_q}; // RQ3
            end
            else
            begin
              acc_d = res_q; // RQ3
            end
          end
          xsde_load_direction_reg:
          begin
            dir_d[2'(dec_q.idx - xsde_dir_idx_lo)] = res_q; // RQ6
          end
          default:
          begin
          end
        endcase
        if (dec_q.op == xsde_xor_literal || dec_q.op == xsde_xor_register)
        begin
          zero_d = (res_q == 8'h00); // RQ4
          zero_we_d = 1'b1; // RQ4
        end
        if (wr_d.en && wr_d.idx >= xsde_dir_idx_lo && wr_d.idx <= xsde_dir_idx_hi)
        begin
          dir_d[2'(wr_d.idx - xsde_dir_idx_lo)] = res_q; // RQ6
        end
      end
      default: state_d = xsde_idle;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state_q <= xsde_idle;
      insn_q <= '0;
      dec_q <= '0;
      opnd_q <= 8'h00;
      res_q <= 8'h00;
      acc_q <= xsde_acc_reset;
      zero_q <= 1'b0;
      zero_we_q <= 1'b0;
      done_q <= 1'b0;
      wr_q <= '0;
      for (int i = 0; i < 3; i++)
      begin
        dir_q[i] <= xsde_dir_reset;
      end
    end
    else
    begin
      state_q <= state_d;
      insn_q <= insn_d;
      dec_q <= dec_d;
      opnd_q <= opnd_d;
      res_q <= res_d;
      acc_q <= acc_d;
      zero_q <= zero_d;
      zero_we_q <= zero_we_d;
      done_q <= done_d;
      wr_q <= wr_d;
      for (int i = 0; i < 3; i++)
      begin
        dir_q[i] <= dir_d[i];
      end
    end
  end

  // register file write, no reset needed for data contents
  always_ff @(posedge i_clk)
  begin
    if (wr_d.en)
    begin
      ram_q[wr_d.idx] <= wr_d.data; // RQ3
    end
  end

  logic busy_q;
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      busy_q <= 1'b0;
    end
    else
    begin
      busy_q <= (state_d != xsde_idle);
    end
  end

  assign o_acc = acc_q;
  assign o_zero = zero_q;
  assign o_zero_we = zero_we_q;
  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_reg_we = wr_q.en;
  assign o_reg_idx = wr_q.idx;
  assign o_reg_data = wr_q.data;
  assign o_dir_a = dir_q[0];
  assign o_dir_b = dir_q[1];
  assign o_dir_c = dir_q[2];
endmodule

// File: hw/xsde_pkg.sv
package xsde_pkg;
  localparam int unsigned xsde_data_w = 8;
  localparam int unsigned xsde_idx_w = 7;
  localparam int unsigned xsde_insn_w = 14;
  // opcode patterns
  localparam logic [5:0] xsde_op_xor_register = 6'h06;
  localparam logic [5:0] xsde_op_nibble_exchange = 6'h0e;
  localparam logic [5:0] xsde_op_xor_literal = 6'h3a;
  localparam logic [10:0] xsde_op_load_direction_reg = 11'h00c;
  localparam logic [6:0] xsde_dir_idx_lo = 7'h05;
  localparam logic [6:0] xsde_dir_idx_hi = 7'h07;
  localparam logic [7:0] xsde_acc_reset = 8'h00;
  localparam logic [7:0] xsde_dir_reset = 8'hff;
  localparam int unsigned xsde_phases = 4;

  typedef enum logic [2:0]
  {
    xsde_nop,
    xsde_xor_literal,
    xsde_xor_register,
    xsde_nibble_exchange,
    xsde_load_direction_reg
  } xsde_op_type;

  typedef struct packed
  {
    xsde_op_type op;
    logic to_reg;
    logic [6:0] idx;
    logic [7:0] lit;
  } xsde_dec_type;

  typedef struct packed
  {
    logic en;
    logic [6:0] idx;
    logic [7:0] data;
  } xsde_wr_type;
endpackage

// File: hw/xsde_decode.sv
module xsde_decode
  import xsde_pkg::*;
(
  input wire logic [13:0] i_insn,
  output xsde_dec_type o_dec
);
  always_comb
  begin
    o_dec.op = xsde_nop;
    o_dec.to_reg = i_insn[7];
    o_dec.idx = i_insn[6:0];
    o_dec.lit = i_insn[7:0];
    if (i_insn[13:8] == xsde_op_xor_literal)
    begin
      o_dec.op = xsde_xor_literal; // RQ1
    end
    else if (i_insn[13:8] == xsde_op_xor_register)
    begin
      o_dec.op = xsde_xor_register; // RQ2
    end
    else if (i_insn[13:8] == xsde_op_nibble_exchange)
    begin
      o_dec.op = xsde_nibble_exchange;
    end
    else if (i_insn[13:3] == xsde_op_load_direction_reg && i_insn[2:0] >= xsde_dir_idx_lo[2:0])
    begin
      o_dec.op = xsde_load_direction_reg; // RQ6
      o_dec.idx = {4'h0, i_insn[2:0]};
    end
  end
endmodule

// File: tb/xsde_chk.sv
module xsde_chk
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_insn_valid,
  input wire logic [13:0] i_insn,
  input wire logic [7:0] o_acc,
  input wire logic o_zero,
  input wire logic o_zero_we,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_reg_we,
  input wire logic [7:0] o_reg_data,
  input wire logic [7:0] o_dir_a
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  sequence take_s;
    i_insn_valid && !o_busy;
  endsequence
  sequence fin_s;
    ##5 o_done;
  endsequence
  done_lat_a: assert property (take_s |-> fin_s) else $error("done");
  busy_len_a: assert property (take_s |=> o_busy [*4] ##1 !o_busy) else $error("busy");
  lit_acc_a: assert property (take_s ##0 i_insn[13:8] == 6'h3a |->
    ##5 o_acc == ($past(o_acc, 5) ^ $past(i_insn[7:0], 5))) else $error("lit");
  reg_dst_a: assert property (take_s ##0 i_insn[13:8] == 6'h06 |->
    ##5 o_reg_we == $past(i_insn[7], 5)) else $error("dst");
  zero_val_a: assert property (o_zero_we |->
    o_zero == ((o_reg_we ? o_reg_data : o_acc) == 8'h00)) else $error("zero");
  swap_acc_a: assert property (take_s ##0 i_insn == 14'h0e05 |->
    ##5 o_acc == {$past(o_dir_a[3:0], 5), $past(o_dir_a[7:4], 5)} && !o_zero_we)
    else $error("swap");
  dir_load_a: assert property (take_s ##0 i_insn == 14'h0065 |->
    ##5 o_dir_a == $past(o_acc, 5) && !o_zero_we) else $error("dir");
endmodule
bind xsde_exec xsde_chk u_xsde_chk (.*);

// File: tb/xsde_exec_tb.sv
module xsde_exec_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 0, i_reset = 1, i_insn_valid = 0, z = 0;
  logic [13:0] i_insn = 0;
  logic [7:0] acc = 0, e, v, o_acc, o_reg_data, o_dir_a, o_dir_b, o_dir_c;
  logic o_zero, o_zero_we, o_busy, o_done, o_reg_we;
  logic [6:0] o_reg_idx;
  logic [7:0] dr [5:7] = '{8'hff, 8'hff, 8'hff};
  int err_count = 0, num_checks = 0, cyc = 0, seed = 32'hfc71afb7, r;
  xsde_exec u_xsde_exec
  (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_insn_valid(i_insn_valid),
    .i_insn(i_insn),
    .o_acc(o_acc),
    .o_zero(o_zero),
    .o_zero_we(o_zero_we),
    .o_busy(o_busy),
    .o_done(o_done),
    .o_reg_we(o_reg_we),
    .o_reg_idx(o_reg_idx),
    .o_reg_data(o_reg_data),
    .o_dir_a(o_dir_a),
    .o_dir_b(o_dir_b),
    .o_dir_c(o_dir_c)
  );
  task automatic chk(input logic [23:0] got, exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always #20 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc > 2000)
    begin
      err_count++;
      conclude();
    end
  end
  function automatic logic [7:0] res(int op, logic [7:0] a, b);
    return op == 2 ? {b[3:0], b[7:4]} : op == 3 ? a : a ^ b;
  endfunction
  task automatic step(int op, logic [7:0] k, logic [6:0] f, logic d, logic h);
    v = op == 0 ? k : dr[f];
    e = res(op, acc, v);
    i_insn = op == 0 ? {6'h3a, k} : op == 1 ? {6'h06, d, f} : {6'h0e, d, f};
    if (op == 3)
      i_insn = {11'h00c, f[2:0]};
    if (op == 4)
      i_insn = {11'h00c, 3'h4};
    i_insn_valid = 1;
    @(negedge i_clk);
    chk(o_busy, 1);
    i_insn_valid = h;
    i_insn = ~i_insn;
    repeat (3) @(negedge i_clk);
    i_insn_valid = 0;
    @(negedge i_clk);
    if (op == 3 || (op == 1 || op == 2) && d)
      dr[f] = e;
    else if (op < 3)
      acc = e;
    if (op < 2)
      z = e == 0;
    chk({o_done, o_busy}, 2'b10);
    chk(o_acc, acc);
    chk({o_dir_c, o_dir_b, o_dir_a}, {dr[7], dr[6], dr[5]});
    chk({o_zero_we, o_zero}, {op < 2, z});
    chk(o_reg_we, (op == 1 || op == 2) && d);
    if ((op == 1 || op == 2) && d)
      chk({o_reg_idx, o_reg_data}, {f, e});
  endtask
  initial
  begin
    repeat (16) @(negedge i_clk);
    i_reset = 0;
    chk({o_acc, o_dir_a}, 16'h00ff);
    step(0, 8'h00, 5, 0, 0);
    step(0, 8'hb5, 5, 0, 1);
    step(0, 8'haf, 5, 0, 0);
    step(2, 0, 5, 0, 1);
    step(3, 0, 5, 0, 0);
    step(1, 0, 5, 1, 1);
    step(4, 0, 5, 0, 1);
    $display("corner done");
    repeat (60)
    begin
      r = $random(seed);
      step(r[12:11], r[7:0], 7'h05 + 7'(r[9:8] % 3), r[10], r[13]);
    end
    $display("random done");
    conclude();
  end
endmodule
